//--- usp_cfg.svh
// Register map, field positions and reset values of the serial port
`ifndef USP_CFG_SVH
`define USP_CFG_SVH
`define USP_ADDR_CTRL 8'h98
`define USP_ADDR_DATA 8'h99
`define USP_CTRL_RESET 8'h40
`define USP_BIT_FLS 7
`define USP_BIT_RSVD 6
`define USP_BIT_FILT 5
`define USP_BIT_REN 4
`define USP_BIT_TX9 3
`define USP_BIT_RX9 2
`define USP_BIT_TXF 1
`define USP_BIT_RXF 0
`define USP_FIFO_DEPTH 16
`define USP_ENTRY_W 9
`define USP_REMOTE_BIT_CYCLES 16
`endif

//--- usp_pkg.sv
// Types of the serial link: byte and receiver states shared by both ends, transmitter states used by the port only
package usp_pkg;
    typedef logic [7:0] usp_byte_t;
    typedef enum logic [1:0] {USP_TX_IDLE, USP_TX_WAIT, USP_TX_SEND} usp_tx_st_t;
    typedef enum logic {USP_RX_IDLE, USP_RX_BITS} usp_rx_st_t;
endpackage

//--- usp_if.sv
// Serial line pair between the port and the remote end
`timescale 1ns/1ps
`default_nettype none
interface usp_if;
    logic dev_to_remote;
    logic remote_to_dev;
    modport dev (output dev_to_remote, input remote_to_dev);
    modport remote (input dev_to_remote, output remote_to_dev);
endinterface
`default_nettype wire

//--- usp_dev.sv
// Serial port end: control register, data buffer, transmitter, receiver
`include "usp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Receive buffer
// ------------------------------------------------------------
module usp_fifo #(
    parameter int W = `USP_ENTRY_W,
    parameter int D = `USP_FIFO_DEPTH
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != (AW+1)'(D));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge CLK) begin
        if (CE && push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else if (CE) begin
            if (push) begin
                wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// ------------------------------------------------------------
// Port top
// ------------------------------------------------------------
module usp_dev (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire usp_pkg::usp_byte_t SFR_WDATA,
    input wire logic SFR_RD,
    output usp_pkg::usp_byte_t SFR_RDATA,
    input wire logic BAUD_TX_OVF,
    input wire logic BAUD_TICK,
    input wire logic BAUD_RUN,
    input wire usp_pkg::usp_byte_t BAUD_RELOAD,
    input wire logic SERIAL_INT_EN,
    output logic SERIAL_IRQ,
    usp_if.dev LINK
);
    import usp_pkg::*;

    function automatic logic hit(input logic [7:0] a, input logic s,
                                 input logic [7:0] t);
        return s && (a == t);
    endfunction

    logic frame9_q, filt_q, ren_q, tx_ninth_q, rx_ninth_q;
    logic tx_flag_q, rx_flag_q;
    logic wr_ctrl, wr_data, rd_data;
    logic tx_flag_set, rx_flag_set;
    logic rx_ninth_view;
    usp_byte_t last_q;
    logic f_in_valid, f_in_ready, f_out_valid, f_pop;
    logic [8:0] f_in_data, f_out_data;

    assign wr_ctrl = hit(SFR_ADDR, SFR_WR, `USP_ADDR_CTRL);
    assign wr_data = hit(SFR_ADDR, SFR_WR, `USP_ADDR_DATA);
    assign rd_data = hit(SFR_ADDR, SFR_RD, `USP_ADDR_DATA);
    assign f_pop = rd_data & f_out_valid;
    assign rx_ninth_view = f_out_valid ? f_out_data[8] : rx_ninth_q;

    // ------------------------------------------------------------
    // Control register and flags
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            frame9_q <= 1'b0;
            filt_q <= 1'b0;
            ren_q <= 1'b0;
            tx_ninth_q <= 1'b0;
        end else if (CE && wr_ctrl) begin
            frame9_q <= SFR_WDATA[`USP_BIT_FLS];
            filt_q <= SFR_WDATA[`USP_BIT_FILT];
            ren_q <= SFR_WDATA[`USP_BIT_REN];
            tx_ninth_q <= SFR_WDATA[`USP_BIT_TX9];
        end
    end

    // A hardware set in the same cycle as a software clear wins
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tx_flag_q <= 1'b0;
            rx_flag_q <= 1'b0;
        end else if (CE) begin
            tx_flag_q <= tx_flag_set
                         | (wr_ctrl ? SFR_WDATA[`USP_BIT_TXF] : tx_flag_q);
            rx_flag_q <= rx_flag_set
                         | (wr_ctrl ? SFR_WDATA[`USP_BIT_RXF] : rx_flag_q);
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rx_ninth_q <= 1'b0;
            last_q <= '0;
        end else if (CE) begin
            if (f_pop) begin
                rx_ninth_q <= f_out_data[8];
                last_q <= f_out_data[7:0];
            end else if (wr_ctrl) begin
                rx_ninth_q <= SFR_WDATA[`USP_BIT_RX9];
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            SFR_RDATA <= '0;
        end else if (CE && SFR_RD) begin
            if (SFR_ADDR == `USP_ADDR_CTRL) begin
                SFR_RDATA <= {frame9_q, 1'b1, filt_q, ren_q, tx_ninth_q,
                              rx_ninth_view, tx_flag_q, rx_flag_q};
            end else if (SFR_ADDR == `USP_ADDR_DATA) begin
                SFR_RDATA <= f_out_valid ? f_out_data[7:0] : last_q;
            end else begin
                SFR_RDATA <= '0;
            end
        end
    end

    assign SERIAL_IRQ = SERIAL_INT_EN & (tx_flag_q | rx_flag_q);

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    usp_tx_st_t tx_st_q;
    logic tx_phase_q, tx_tick, tx_line_q;
    logic [10:0] tx_shift_q;
    logic [3:0] tx_left_q;

    // Halving the overflow stream gives one tick per bit
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tx_phase_q <= 1'b0;
        end else if (CE && BAUD_TX_OVF) begin
            tx_phase_q <= ~tx_phase_q;
        end
    end
    assign tx_tick = BAUD_TX_OVF & tx_phase_q;
    // The tick that drives the stop bit is the one with a single bit left
    assign tx_flag_set = tx_tick && tx_st_q == USP_TX_SEND
                         && tx_left_q == 4'h1;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tx_st_q <= USP_TX_IDLE;
            tx_shift_q <= '1;
            tx_left_q <= '0;
            tx_line_q <= 1'b1;
        end else if (CE) begin
            case (tx_st_q)
                USP_TX_IDLE: begin
                    // Writes while a frame is in flight are ignored
                    if (wr_data) begin
                        tx_shift_q <= {1'b1, frame9_q ? tx_ninth_q : 1'b1,
                                       SFR_WDATA, 1'b0};
                        tx_left_q <= frame9_q ? 4'hb : 4'ha;
                        tx_st_q <= USP_TX_WAIT;
                    end
                end
                USP_TX_WAIT, USP_TX_SEND: begin
                    if (tx_tick) begin
                        if (tx_left_q == 4'h0) begin
                            tx_st_q <= USP_TX_IDLE;
                        end else begin
                            tx_line_q <= tx_shift_q[0];
                            tx_shift_q <= {1'b1, tx_shift_q[10:1]};
                            tx_left_q <= tx_left_q - 4'h1;
                            tx_st_q <= USP_TX_SEND;
                        end
                    end
                end
                default: tx_st_q <= USP_TX_IDLE;
            endcase
        end
    end
    assign LINK.dev_to_remote = tx_line_q;

    // ------------------------------------------------------------
    // Receive timer and receiver
    // ------------------------------------------------------------
    usp_rx_st_t rx_st_q;
    logic rx_s1_q, rx_s2_q, rx_prev_q;
    usp_byte_t rx_cnt_q;
    logic rx_ovf, rx_phase_q, start_det;
    logic [9:0] rx_bits_q;
    logic [3:0] rx_idx_q;
    logic rx_last, ninth_v, pass;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
            rx_prev_q <= 1'b1;
        end else if (CE) begin
            rx_s1_q <= LINK.remote_to_dev;
            rx_s2_q <= rx_s1_q;
            rx_prev_q <= rx_s2_q;
        end
    end

    assign start_det = ren_q && rx_st_q == USP_RX_IDLE
                       && rx_prev_q && !rx_s2_q;
    assign rx_ovf = BAUD_RUN && BAUD_TICK && rx_cnt_q == 8'hff && !start_det;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rx_cnt_q <= '0;
        end else if (CE) begin
            if (start_det) begin
                rx_cnt_q <= BAUD_RELOAD;
            end else if (BAUD_RUN && BAUD_TICK) begin
                rx_cnt_q <= (rx_cnt_q == 8'hff) ? BAUD_RELOAD
                                                : rx_cnt_q + 8'h01;
            end
        end
    end

    assign rx_last = rx_idx_q == (frame9_q ? 4'ha : 4'h9);
    assign ninth_v = frame9_q ? rx_bits_q[8] : rx_s2_q;
    assign pass = !filt_q || ninth_v;
    assign f_in_valid = rx_ovf && !rx_phase_q && rx_st_q == USP_RX_BITS
                        && rx_last && pass;
    assign f_in_data = {ninth_v, rx_bits_q[7:0]};
    // A full buffer refuses the push, so the newest frame is lost
    assign rx_flag_set = f_in_valid & f_in_ready;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rx_st_q <= USP_RX_IDLE;
            rx_phase_q <= 1'b0;
            rx_idx_q <= '0;
            rx_bits_q <= '0;
        end else if (CE) begin
            case (rx_st_q)
                USP_RX_IDLE: begin
                    if (start_det) begin
                        rx_st_q <= USP_RX_BITS;
                        rx_phase_q <= 1'b0;
                        rx_idx_q <= '0;
                    end
                end
                USP_RX_BITS: begin
                    if (rx_ovf) begin
                        rx_phase_q <= ~rx_phase_q;
                        if (!rx_phase_q) begin
                            if (rx_idx_q == 4'h0 && rx_s2_q) begin
                                rx_st_q <= USP_RX_IDLE;
                            end else if (rx_last) begin
                                rx_st_q <= USP_RX_IDLE;
                            end else begin
                                if (rx_idx_q != 4'h0) begin
                                    rx_bits_q[rx_idx_q - 4'h1] <= rx_s2_q;
                                end
                                rx_idx_q <= rx_idx_q + 4'h1;
                            end
                        end
                    end
                end
                default: rx_st_q <= USP_RX_IDLE;
            endcase
        end
    end

    usp_fifo #(.W(`USP_ENTRY_W), .D(`USP_FIFO_DEPTH)) u_fifo (
        .CLK(CLK),
        .RST(RST),
        .CE(CE),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(f_in_data),
        .out_valid(f_out_valid),
        .out_ready(rd_data),
        .out_data(f_out_data)
    );
endmodule
`default_nettype wire

//--- usp_remote.sv
// Remote serial end: fixed-rate transmitter and receiver on the link
`include "usp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module usp_remote #(
    parameter int BIT_CYCLES = `USP_REMOTE_BIT_CYCLES
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic NINE_BIT,
    input wire logic SEND_VALID,
    output logic SEND_READY,
    input wire usp_pkg::usp_byte_t SEND_DATA,
    input wire logic SEND_NINTH,
    output logic RECV_VALID,
    output usp_pkg::usp_byte_t RECV_DATA,
    output logic RECV_NINTH,
    output logic RECV_STOP_ERR,
    usp_if.remote LINK
);
    import usp_pkg::*;
    localparam int CW = $clog2(BIT_CYCLES) + 1;

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    logic [10:0] sh_q;
    logic [3:0] left_q;
    logic [CW-1:0] tdiv_q;
    logic line_q;

    assign SEND_READY = (left_q == 4'h0);
    assign LINK.remote_to_dev = line_q;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sh_q <= '1;
            left_q <= '0;
            tdiv_q <= '0;
            line_q <= 1'b1;
        end else if (CE) begin
            if (SEND_VALID && SEND_READY) begin
                // Ninth carries address or data marking
                sh_q <= {1'b1, NINE_BIT ? SEND_NINTH : 1'b1, SEND_DATA, 1'b0};
                left_q <= NINE_BIT ? 4'hb : 4'ha;
                tdiv_q <= '0;
            end else if (left_q != 4'h0) begin
                if (tdiv_q == '0) begin
                    line_q <= sh_q[0];
                    sh_q <= {1'b1, sh_q[10:1]};
                end
                if (tdiv_q == CW'(BIT_CYCLES - 1)) begin
                    tdiv_q <= '0;
                    left_q <= left_q - 4'h1;
                end else begin
                    tdiv_q <= tdiv_q + 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Receiver, sampling at mid-bit
    // ------------------------------------------------------------
    usp_rx_st_t st_q;
    logic s1_q, s2_q, prev_q;
    logic [CW-1:0] rdiv_q;
    logic [3:0] idx_q;
    logic [9:0] bits_q;
    logic last;

    assign last = idx_q == (NINE_BIT ? 4'ha : 4'h9);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            prev_q <= 1'b1;
        end else if (CE) begin
            s1_q <= LINK.dev_to_remote;
            s2_q <= s1_q;
            prev_q <= s2_q;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_q <= USP_RX_IDLE;
            rdiv_q <= '0;
            idx_q <= '0;
            bits_q <= '0;
            RECV_VALID <= 1'b0;
            RECV_DATA <= '0;
            RECV_NINTH <= 1'b0;
            RECV_STOP_ERR <= 1'b0;
        end else if (CE) begin
            RECV_VALID <= 1'b0;
            case (st_q)
                USP_RX_IDLE: begin
                    if (prev_q && !s2_q) begin
                        st_q <= USP_RX_BITS;
                        rdiv_q <= CW'(BIT_CYCLES / 2);
                        idx_q <= '0;
                    end
                end
                USP_RX_BITS: begin
                    if (rdiv_q != '0) begin
                        rdiv_q <= rdiv_q - 1'b1;
                    end else begin
                        rdiv_q <= CW'(BIT_CYCLES - 1);
                        if (idx_q == 4'h0 && s2_q) begin
                            st_q <= USP_RX_IDLE;
                        end else if (last) begin
                            st_q <= USP_RX_IDLE;
                            RECV_VALID <= 1'b1;
                            RECV_DATA <= bits_q[7:0];
                            RECV_NINTH <= NINE_BIT ? bits_q[8] : s2_q;
                            RECV_STOP_ERR <= !s2_q;
                        end else begin
                            if (idx_q != 4'h0) begin
                                bits_q[idx_q - 4'h1] <= s2_q;
                            end
                            idx_q <= idx_q + 4'h1;
                        end
                    end
                end
                default: st_q <= USP_RX_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

//--- usp_checker.sv
// Line-level checks on both directions of the serial link
`timescale 1ns/1ps
`default_nettype none
module usp_checker (
    input wire logic CLK,
    input wire logic RST,
    input wire logic dev_to_remote,
    input wire logic remote_to_dev
);
    // ----------------------------------------
    // Run-length helpers
    // ----------------------------------------
    // One bit is 16 cycles at the bench baud setting (2 x 8-cycle overflow)
    localparam int BIT = 16;
    localparam int LOW_MAX = 160;
    logic [1:0] ln;
    logic [1:0] prev_q;
    logic [7:0] run_q [2];
    logic dev_seen_q;
    assign ln = {remote_to_dev, dev_to_remote};
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            prev_q <= 2'h3;
            for (int i = 0; i < 2; i++) begin
                run_q[i] <= 8'h00;
            end
        end else begin
            prev_q <= ln;
            for (int i = 0; i < 2; i++) begin
                if (ln[i] != prev_q[i]) begin
                    run_q[i] <= 8'h01;
                end else if (run_q[i] != 8'hff) begin
                    run_q[i] <= run_q[i] + 8'h01;
                end
            end
        end
    end
    // First start after reset is not on a known tick phase
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            dev_seen_q <= 1'b0;
        end else if (!ln[0] && prev_q[0]) begin
            dev_seen_q <= 1'b1;
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    a_idle_at_release: assert property (
        $fell(RST) |-> ln == 2'h3) else $error("line not idle after reset");
    a_dev_low_grid: assert property (
        ln[0] && !prev_q[0] |-> run_q[0][3:0] == 4'h0)
        else $error("device low run off the bit grid");
    a_dev_high_grid: assert property (
        !ln[0] && prev_q[0] && dev_seen_q && run_q[0] < LOW_MAX
        |-> run_q[0][3:0] == 4'h0) else $error("device start off the grid");
    a_dev_frame_len: assert property (
        !ln[0] && !prev_q[0] |-> run_q[0] < LOW_MAX)
        else $error("device line low too long");
    a_dev_stop_high: assert property (
        !ln[0] && prev_q[0] |-> run_q[0] >= BIT)
        else $error("device stop bit too short");
    a_rem_low_grid: assert property (
        ln[1] && !prev_q[1] |-> run_q[1][3:0] == 4'h0)
        else $error("remote low run off the bit grid");
    a_rem_frame_len: assert property (
        !ln[1] && !prev_q[1] |-> run_q[1] < LOW_MAX)
        else $error("remote line low too long");
    a_rem_stop_high: assert property (
        !ln[1] && prev_q[1] |-> run_q[1] >= BIT)
        else $error("remote stop bit too short");
    c_full_duplex: cover property (!ln[0] && !ln[1]);
    c_long_low: cover property (ln[0] && !prev_q[0] && run_q[0] >= 8'd144);
    c_rem_start: cover property ($fell(ln[1]));
endmodule
`default_nettype wire

//--- usp_dev_tb_top.sv
// Self-checking bench: port and remote end joined across the link
`include "usp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module usp_dev_tb_top;
    import usp_pkg::*;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic [7:0] SFR_ADDR = 8'h00;
    logic SFR_WR = 1'b0;
    logic SFR_RD = 1'b0;
    usp_byte_t SFR_WDATA = 8'h00;
    usp_byte_t SFR_RDATA;
    logic BAUD_TX_OVF = 1'b0;
    logic SERIAL_INT_EN = 1'b0;
    logic SERIAL_IRQ;
    logic NINE_BIT = 1'b0;
    logic SEND_VALID = 1'b0;
    logic SEND_READY;
    usp_byte_t SEND_DATA = 8'h00;
    logic SEND_NINTH = 1'b0;
    logic RECV_VALID;
    usp_byte_t RECV_DATA;
    logic RECV_NINTH;
    logic RECV_STOP_ERR;
    logic [2:0] ovf_cnt = 3'h0;
    logic [31:0] seed = 32'd30524;
    int error_cnt = 0;
    int total_checks = 0;
    usp_if link ();
    // ----------------------------------------
    // Design and checker
    // ----------------------------------------
    // Hidden rx counter reloads to 0xf8 and counts every cycle: 8-cycle overflow
    usp_dev u_usp_dev (
        .CLK(CLK), .RST(RST), .CE(1'b1), .SFR_ADDR(SFR_ADDR),
        .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA), .SFR_RD(SFR_RD),
        .SFR_RDATA(SFR_RDATA), .BAUD_TX_OVF(BAUD_TX_OVF), .BAUD_TICK(1'b1),
        .BAUD_RUN(1'b1), .BAUD_RELOAD(8'hf8), .SERIAL_INT_EN(SERIAL_INT_EN),
        .SERIAL_IRQ(SERIAL_IRQ), .LINK(link));
    usp_remote u_usp_remote (
        .CLK(CLK), .RST(RST), .CE(1'b1), .NINE_BIT(NINE_BIT),
        .SEND_VALID(SEND_VALID), .SEND_READY(SEND_READY),
        .SEND_DATA(SEND_DATA), .SEND_NINTH(SEND_NINTH),
        .RECV_VALID(RECV_VALID), .RECV_DATA(RECV_DATA),
        .RECV_NINTH(RECV_NINTH), .RECV_STOP_ERR(RECV_STOP_ERR), .LINK(link));
    usp_checker u_usp_checker (
        .CLK(CLK), .RST(RST), .dev_to_remote(link.dev_to_remote),
        .remote_to_dev(link.remote_to_dev));
    always #5 CLK = ~CLK;
    always @(posedge CLK) begin
        ovf_cnt <= ovf_cnt + 3'h1;
        BAUD_TX_OVF <= (ovf_cnt == 3'h7);
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    function automatic logic passes(input logic filt, fs, nin);
        return !filt || (fs ? nin : 1'b1);
    endfunction
    task automatic report_and_stop();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Bounded wait on remote ready (sel=1) or remote receive pulse (sel=0)
    task automatic wait_hi(input logic sel);
        for (int n = 0; n < 600; n++) begin
            @(negedge CLK);
            if ((sel ? SEND_READY : RECV_VALID) === 1'b1) return;
        end
        check(9'h000, 9'h001);
        report_and_stop();
    endtask
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        SFR_ADDR <= a;
        SFR_WDATA <= d;
        SFR_WR <= 1'b1;
        @(posedge CLK);
        SFR_WR <= 1'b0;
    endtask
    task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge CLK);
        SFR_ADDR <= a;
        SFR_RD <= 1'b1;
        @(posedge CLK);
        SFR_RD <= 1'b0;
        #1 d = SFR_RDATA;
    endtask
    task automatic send(input logic [7:0] d, input logic n);
        @(posedge CLK);
        SEND_DATA <= d;
        SEND_NINTH <= n;
        SEND_VALID <= 1'b1;
        wait_hi(1'b1);
        @(posedge CLK);
        SEND_VALID <= 1'b0;
    endtask
    task automatic do_reset();
        RST <= 1'b1;
        repeat (16) @(posedge CLK);
        RST <= 1'b0;
        repeat (40) @(posedge CLK);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] v;
        logic [7:0] d;
        logic [7:0] tx_b;
        logic [7:0] rx_b;
        logic fs, nin, filt, ren, tx9, en, pushed;
        logic [7:0] q [17];
        do_reset();
        sfr_rd(`USP_ADDR_CTRL, v);
        check({1'b0, v}, {1'b0, `USP_CTRL_RESET});
        sfr_rd(8'h9a, v);
        check({1'b0, v}, 9'h000);
        // Every mode, filter, ninth and enable combination, both ways at once
        for (int i = 0; i < 16; i++) begin
            {ren, filt, nin, fs} = i[3:0];
            seed = xs(seed);
            {rx_b, tx9, en, tx_b} = {seed[23:16], seed[8], seed[9], seed[7:0]};
            if (i < 2) begin
                {rx_b, tx_b} = 16'h0000;
            end
            pushed = ren && passes(filt, fs, nin);
            @(posedge CLK);
            NINE_BIT <= fs;
            SERIAL_INT_EN <= en;
            sfr_wr(`USP_ADDR_CTRL, {fs, 1'b0, filt, ren, tx9, 3'h0});
            fork
                begin
                    sfr_wr(`USP_ADDR_DATA, tx_b);
                    wait_hi(1'b0);
                    check({RECV_NINTH & fs, RECV_DATA}, {tx9 & fs, tx_b});
                    check({8'h00, RECV_STOP_ERR}, 9'h000);
                end
                send(rx_b, nin);
            join
            wait_hi(1'b1);
            repeat (16) @(posedge CLK);
            sfr_rd(`USP_ADDR_CTRL, v);
            check({2'h0, v[7:3], v[1:0]},
                  {2'h0, fs, 1'b1, filt, ren, tx9, 1'b1, pushed});
            check({8'h00, SERIAL_IRQ}, {8'h00, en});
            if (pushed) begin
                check({8'h00, v[2]}, {8'h00, fs ? nin : 1'b1});
                sfr_rd(`USP_ADDR_DATA, d);
                check({1'b0, d}, {1'b0, rx_b});
            end
            sfr_wr(`USP_ADDR_CTRL, {fs, 1'b0, filt, ren, tx9, 3'h0});
            #1 check({8'h00, SERIAL_IRQ}, 9'h000);
        end
        // Second reset, then overfill the receive buffer by one frame
        do_reset();
        sfr_rd(`USP_ADDR_CTRL, v);
        check({1'b0, v}, {1'b0, `USP_CTRL_RESET});
        @(posedge CLK);
        NINE_BIT <= 1'b0;
        sfr_wr(`USP_ADDR_CTRL, 8'h10);
        for (int k = 0; k < 17; k++) begin
            seed = xs(seed);
            q[k] = seed[7:0];
            send(q[k], 1'b0);
        end
        wait_hi(1'b1);
        repeat (16) @(posedge CLK);
        for (int k = 0; k < 17; k++) begin
            sfr_rd(`USP_ADDR_DATA, d);
            check({1'b0, d}, {1'b0, q[k < 16 ? k : 15]});
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
